// ==== logic/pdm_defines.svh ====
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

// Register byte offsets on the APB slave.
`define PDM_OFF_CTRL_ONE 8'h00
`define PDM_OFF_CTRL_TWO 8'h04
`define PDM_OFF_IRQ_STATUS 8'h08
`define PDM_OFF_IRQ_MASK 8'h0c
`define PDM_OFF_MODE 8'h10

// Field positions of the first control register.
`define PDM_C1_SSEL 7
`define PDM_C1_STS_HI 6
`define PDM_C1_STS_LO 4
`define PDM_C1_LSR 3
`define PDM_C1_RSV 2

// Field positions of the second control register.
`define PDM_C2_DAT 3
`define PDM_C2_ONES_HI 7
`define PDM_C2_ONES_LO 4
`define PDM_C2_ONE 2
`define PDM_C2_RSV_HI 1
`define PDM_C2_RSV_LO 0

// Reset values of the control registers.
`define PDM_C1_RESET 8'h00
`define PDM_C2_RESET 8'hf4

// Interrupt status bits.
`define PDM_EV_SETTLED 0
`define PDM_EV_DIRECT 1
`define PDM_EV_SUBACT 2
`define PDM_EV_W 3

// Settling wait in system clock states for the shortest code.
`define PDM_SETTLE_BASE 8192
`define PDM_CNT_W 18

`endif

// ==== logic/pdm_pkg.sv ====
package pdm_pkg;

  typedef enum logic [2:0] {
    PDM_ACTIVE,
    PDM_SLEEP,
    PDM_STANDBY,
    PDM_WATCH,
    PDM_SUBACTIVE,
    PDM_SETTLE
  } pdm_mode_t;

endpackage

// ==== logic/pdm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module pdm_top #(
  parameter int SETTLE_BASE = `PDM_SETTLE_BASE
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU and interrupt controller, same clock.
  input wire logic sleep_exec,
  input wire logic sleep_wake,
  input wire logic timebase_watch_select,
  input wire logic irq_mask_global,
  input wire logic direct_irq_enable,
  // Wake pins from outside the clock domain.
  input wire logic wake_ext_pin,
  input wire logic wake_watch_pin,
  // Power state outputs.
  output logic [2:0] mode_code,
  output logic cpu_on_subclock,
  output logic osc_run,
  output logic cpu_run,
  output logic direct_irq_req,
  output logic irq
);

  typedef struct packed {
    pdm_pkg::pdm_mode_t mode;
    logic standby_select;
    logic [2:0] settle_wait_select;
    logic low_speed_resume;
    logic rsv_one;
    logic direct_active_transfer;
    logic [1:0] rsv_two;
    logic [`PDM_CNT_W-1:0] cnt;
    logic [`PDM_EV_W-1:0] irq_sts;
    logic [`PDM_EV_W-1:0] irq_msk;
    logic dt_req;
    logic [31:0] rdata;
    logic err;
    logic wext_s1;
    logic wext_s2;
    logic wwat_s1;
    logic wwat_s2;
  } pdm_state_t;

  pdm_state_t st_r;
  pdm_state_t st_nxt;

  function automatic logic [`PDM_CNT_W-1:0] settle_cycles(input logic [2:0] code);
    logic [`PDM_CNT_W-1:0] base;
    base = `PDM_CNT_W'(SETTLE_BASE);
    if (code[2]) begin
      settle_cycles = base << 4;
    end else begin
      settle_cycles = base << code[1:0];
    end
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `PDM_OFF_CTRL_ONE) || (a == `PDM_OFF_CTRL_TWO) ||
              (a == `PDM_OFF_IRQ_STATUS) || (a == `PDM_OFF_IRQ_MASK) ||
              (a == `PDM_OFF_MODE);
  endfunction

  logic [`PDM_EV_W-1:0] ev;
  logic wr;
  logic rd;
  logic [7:0] c1_rd;
  logic [7:0] c2_rd;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable;

  always_comb begin
    c1_rd = 8'h00;
    c1_rd[`PDM_C1_SSEL] = st_r.standby_select;
    c1_rd[`PDM_C1_STS_HI:`PDM_C1_STS_LO] = st_r.settle_wait_select;
    c1_rd[`PDM_C1_LSR] = st_r.low_speed_resume;
    c1_rd[`PDM_C1_RSV] = st_r.rsv_one;
    // The direct transfer bit is write-only, so it reads back as zero.
    c2_rd = `PDM_C2_RESET;
    c2_rd[`PDM_C2_RSV_HI:`PDM_C2_RSV_LO] = st_r.rsv_two;
  end

  always_comb begin
    st_nxt = st_r;
    ev = '0;
    st_nxt.dt_req = 1'b0;
    st_nxt.wext_s1 = wake_ext_pin;
    st_nxt.wext_s2 = st_r.wext_s1;
    st_nxt.wwat_s1 = wake_watch_pin;
    st_nxt.wwat_s2 = st_r.wwat_s1;
    if (wr) begin
      case (paddr)
        `PDM_OFF_CTRL_ONE: begin
          if (st_r.mode == pdm_pkg::PDM_ACTIVE) begin
            st_nxt.standby_select = pwdata[`PDM_C1_SSEL];
          end
          st_nxt.settle_wait_select = pwdata[`PDM_C1_STS_HI:`PDM_C1_STS_LO];
          st_nxt.low_speed_resume = pwdata[`PDM_C1_LSR];
          st_nxt.rsv_one = pwdata[`PDM_C1_RSV];
        end
        `PDM_OFF_CTRL_TWO: begin
          if (st_r.mode == pdm_pkg::PDM_SUBACTIVE) begin
            st_nxt.direct_active_transfer = pwdata[`PDM_C2_DAT];
          end
          st_nxt.rsv_two = pwdata[`PDM_C2_RSV_HI:`PDM_C2_RSV_LO];
        end
        `PDM_OFF_IRQ_STATUS: begin
          st_nxt.irq_sts = st_r.irq_sts & ~pwdata[`PDM_EV_W-1:0];
        end
        `PDM_OFF_IRQ_MASK: begin
          st_nxt.irq_msk = pwdata[`PDM_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    case (st_r.mode)
      pdm_pkg::PDM_ACTIVE: begin
        if (sleep_exec) begin
          if (!st_r.standby_select) begin
            st_nxt.mode = pdm_pkg::PDM_SLEEP;
          end else if (timebase_watch_select) begin
            st_nxt.mode = pdm_pkg::PDM_WATCH;
          end else begin
            st_nxt.mode = pdm_pkg::PDM_STANDBY;
          end
        end
      end
      pdm_pkg::PDM_SLEEP: begin
        if (sleep_wake) begin
          st_nxt.mode = pdm_pkg::PDM_ACTIVE;
        end
      end
      pdm_pkg::PDM_STANDBY: begin
        // Standby select is left alone here, so it is still set on return.
        if (st_r.wext_s2 && !irq_mask_global) begin
          st_nxt.mode = pdm_pkg::PDM_SETTLE;
          st_nxt.cnt = settle_cycles(st_r.settle_wait_select) - 1'b1;
        end
      end
      pdm_pkg::PDM_WATCH: begin
        if (st_r.wwat_s2 && !irq_mask_global) begin
          if (st_r.low_speed_resume) begin
            st_nxt.mode = pdm_pkg::PDM_SUBACTIVE;
            ev[`PDM_EV_SUBACT] = 1'b1;
          end else begin
            st_nxt.mode = pdm_pkg::PDM_SETTLE;
            st_nxt.cnt = settle_cycles(st_r.settle_wait_select) - 1'b1;
          end
        end
      end
      pdm_pkg::PDM_SUBACTIVE: begin
        if (sleep_exec) begin
          if (st_r.direct_active_transfer && !st_r.low_speed_resume &&
              !irq_mask_global && direct_irq_enable) begin
            st_nxt.mode = pdm_pkg::PDM_SETTLE;
            st_nxt.cnt = settle_cycles(st_r.settle_wait_select) - 1'b1;
            st_nxt.dt_req = 1'b1;
            ev[`PDM_EV_DIRECT] = 1'b1;
          end else begin
            // A blocked direct transfer falls back to the plain watch entry.
            st_nxt.mode = pdm_pkg::PDM_WATCH;
          end
        end
      end
      pdm_pkg::PDM_SETTLE: begin
        if (st_r.cnt == '0) begin
          st_nxt.mode = pdm_pkg::PDM_ACTIVE;
          ev[`PDM_EV_SETTLED] = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      default: begin
        st_nxt.mode = pdm_pkg::PDM_ACTIVE;
      end
    endcase
    // A new event wins over a clear in the same cycle.
    st_nxt.irq_sts = st_nxt.irq_sts | ev;
    if (rd) begin
      st_nxt.err = !reg_hit(paddr);
      case (paddr)
        `PDM_OFF_CTRL_ONE: st_nxt.rdata = {24'h000000, c1_rd};
        `PDM_OFF_CTRL_TWO: st_nxt.rdata = {24'h000000, c2_rd};
        `PDM_OFF_IRQ_STATUS: st_nxt.rdata = {29'h0, st_r.irq_sts};
        `PDM_OFF_IRQ_MASK: st_nxt.rdata = {29'h0, st_r.irq_msk};
        `PDM_OFF_MODE: st_nxt.rdata = {29'h0, st_r.mode};
        default: st_nxt.rdata = 32'h00000000;
      endcase
    end else if (!psel) begin
      st_nxt.err = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.mode <= pdm_pkg::PDM_ACTIVE;
      st_r.standby_select <= 1'b0;
      st_r.settle_wait_select <= 3'h0;
      st_r.low_speed_resume <= 1'b0;
      st_r.rsv_one <= 1'b0;
      st_r.direct_active_transfer <= 1'b0;
      st_r.rsv_two <= 2'h0;
      st_r.cnt <= '0;
      st_r.irq_sts <= '0;
      st_r.irq_msk <= '0;
      st_r.dt_req <= 1'b0;
      st_r.rdata <= 32'h00000000;
      st_r.err <= 1'b0;
      st_r.wext_s1 <= 1'b0;
      st_r.wext_s2 <= 1'b0;
      st_r.wwat_s1 <= 1'b0;
      st_r.wwat_s2 <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready = 1'b1;
  assign prdata = st_r.rdata;
  assign pslverr = st_r.err && psel && penable;
  assign mode_code = st_r.mode;
  assign cpu_on_subclock = (st_r.mode == pdm_pkg::PDM_SUBACTIVE);
  assign osc_run = (st_r.mode == pdm_pkg::PDM_ACTIVE) || (st_r.mode == pdm_pkg::PDM_SLEEP) ||
                   (st_r.mode == pdm_pkg::PDM_SETTLE);
  assign cpu_run = (st_r.mode == pdm_pkg::PDM_ACTIVE) || (st_r.mode == pdm_pkg::PDM_SUBACTIVE);
  assign direct_irq_req = st_r.dt_req;
  assign irq = |(st_r.irq_sts & st_r.irq_msk);

  // Helper logic measuring each settling interval against its selected length.
  logic [`PDM_CNT_W:0] h_cnt;
  logic [`PDM_CNT_W-1:0] h_exp;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_cnt <= '0;
      // Starts at the count of the reset code, so the first check after reset agrees.
      h_exp <= `PDM_CNT_W'(SETTLE_BASE);
    end else if (st_r.mode == pdm_pkg::PDM_SETTLE) begin
      h_cnt <= h_cnt + 1'b1;
    end else begin
      h_cnt <= '0;
      h_exp <= settle_cycles(st_r.settle_wait_select);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence dt_start_s;
    st_r.mode == pdm_pkg::PDM_SUBACTIVE && sleep_exec && st_r.direct_active_transfer &&
    !st_r.low_speed_resume && !irq_mask_global && direct_irq_enable;
  endsequence

  sequence dt_walk_s;
    direct_irq_req && st_r.mode == pdm_pkg::PDM_SETTLE ##1 !direct_irq_req;
  endsequence

  sleep_entry_a: assert property (
    st_r.mode == pdm_pkg::PDM_ACTIVE && sleep_exec && !st_r.standby_select
    |=> st_r.mode == pdm_pkg::PDM_SLEEP)
    else $error("sleep instruction did not enter sleep mode");

  deep_entry_a: assert property (
    st_r.mode == pdm_pkg::PDM_ACTIVE && sleep_exec && st_r.standby_select
    |=> st_r.mode == ($past(timebase_watch_select) ? pdm_pkg::PDM_WATCH : pdm_pkg::PDM_STANDBY))
    else $error("wrong deep mode entered");

  ssel_guard_a: assert property (
    $changed(st_r.standby_select) |-> $past(st_r.mode) == pdm_pkg::PDM_ACTIVE)
    else $error("standby select changed outside active mode");

  ssel_keep_a: assert property (
    st_r.mode == pdm_pkg::PDM_SETTLE && st_r.standby_select ##1
    st_r.mode == pdm_pkg::PDM_ACTIVE |-> st_r.standby_select)
    else $error("standby select lost on wake");

  dat_guard_a: assert property (
    $changed(st_r.direct_active_transfer) |-> $past(st_r.mode) == pdm_pkg::PDM_SUBACTIVE)
    else $error("direct transfer bit changed outside subactive mode");

  settle_len_a: assert property (
    $fell(st_r.mode == pdm_pkg::PDM_SETTLE) |-> $past(h_cnt) + 1'b1 == {1'b0, h_exp})
    else $error("settling interval has wrong length");

  settle_min_a: assert property (
    st_r.mode != pdm_pkg::PDM_SETTLE && st_r.settle_wait_select == 3'h0
    |-> h_exp == `PDM_CNT_W'(SETTLE_BASE) || $changed(st_r.settle_wait_select))
    else $error("shortest settle code gives wrong count");

  sub_resume_a: assert property (
    st_r.mode == pdm_pkg::PDM_WATCH && st_r.wwat_s2 && !irq_mask_global && st_r.low_speed_resume
    |=> st_r.mode == pdm_pkg::PDM_SUBACTIVE && cpu_on_subclock)
    else $error("watch wake did not enter subactive mode");

  direct_walk_a: assert property (
    dt_start_s |=> dt_walk_s)
    else $error("direct transfer request sequence wrong");

  direct_block_a: assert property (
    st_r.mode == pdm_pkg::PDM_SUBACTIVE && sleep_exec &&
    !(st_r.direct_active_transfer && !st_r.low_speed_resume && !irq_mask_global && direct_irq_enable)
    |=> st_r.mode == pdm_pkg::PDM_WATCH && !direct_irq_req)
    else $error("blocked direct transfer did not enter watch mode");

  ctrl_two_rd_a: assert property (
    rd && paddr == `PDM_OFF_CTRL_TWO |=> prdata[7:4] == 4'hf && prdata[2] && !prdata[3])
    else $error("control two fixed bits read wrong");

  ctrl_one_rd_a: assert property (
    rd && paddr == `PDM_OFF_CTRL_ONE |=> prdata[1:0] == 2'h0)
    else $error("control one low bits not zero");

endmodule
`default_nettype wire

// ==== sim/tb_pdm_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"
module tb_pdm_top;
  // A short settling base keeps every settling wait between 4 and 64 cycles.
  localparam int SB = 4;
  logic pclk, presetn, psel, penable, pwrite, sleep_exec, sleep_wake;
  logic tws, gmask, dt_en, wake_ext, wake_watch, perr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, exp_c2;
  logic pready, pslverr, cpu_sub, osc_run, cpu_run, dreq, irq;
  logic [2:0] mode_code;
  int errors, n_compared, n, exp_sts, code, sh;
  int codes[6] = '{0, 1, 2, 3, 4, 7};

  pdm_top #(.SETTLE_BASE(SB)) i_pdm_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .sleep_wake(sleep_wake), .timebase_watch_select(tws),
    .irq_mask_global(gmask), .direct_irq_enable(dt_en), .wake_ext_pin(wake_ext),
    .wake_watch_pin(wake_watch), .mode_code(mode_code), .cpu_on_subclock(cpu_sub),
    .osc_run(osc_run), .cpu_run(cpu_run), .direct_irq_req(dreq), .irq(irq)
  );

  task automatic test_done();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i <= 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 16) begin
        errors++;
        test_done();
      end
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Counts edges until the mode shows up; n holds the count on return.
  task automatic wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode_code !== m) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        errors++;
        test_done();
      end
    end
  endtask

  task automatic slp();
    @(posedge pclk);
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask

  task automatic settle(input int k, input logic dr);
    wait_mode(3'd5, 8);
    chk(dreq, dr);
    chk(cpu_run, 1'b0);
    chk(osc_run, 1'b1);
    wait_mode(3'd0, 200);
    chk(n, SB << k);
    chk(cpu_run, 1'b1);
    exp_sts |= 1 | (dr << 1);
    wake_ext <= 1'b0;
  endtask

  task automatic sts();
    rchk(`PDM_OFF_IRQ_STATUS, exp_sts);
    chk(irq, exp_sts[0]);
    wr(`PDM_OFF_IRQ_STATUS, 32'hff);
    exp_sts = 0;
    @(posedge pclk);
    chk(irq, 1'b0);
  endtask

  task automatic to_sub();
    wr(`PDM_OFF_CTRL_ONE, 32'h88);
    wake_watch <= 1'b1;
    wait_mode(3'd4, 8);
    wake_watch <= 1'b0;
    exp_sts |= 4;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, sleep_exec, sleep_wake, tws, gmask} = '0;
    {wake_ext, wake_watch, paddr, pwdata} = '0;
    dt_en = 1'b1;
    errors = 0;
    n_compared = 0;
    exp_sts = 0;
    n = $urandom(32'h82bd);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`PDM_OFF_CTRL_ONE, 32'h00);
    rchk(`PDM_OFF_CTRL_TWO, 32'hf4);
    rchk(`PDM_OFF_MODE, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(perr, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(`PDM_OFF_CTRL_ONE, d);
      rchk(`PDM_OFF_CTRL_ONE, d & 32'hfc);
      wr(`PDM_OFF_CTRL_TWO, d | 32'h08);
      exp_c2 = {24'h0, 6'h3d, d[1:0]};
      rchk(`PDM_OFF_CTRL_TWO, exp_c2);
    end
    wr(`PDM_OFF_IRQ_MASK, 32'h1);
    wr(`PDM_OFF_CTRL_ONE, 32'h00);
    slp();
    wait_mode(3'd1, 4);
    sleep_wake <= 1'b1;
    wait_mode(3'd0, 4);
    sleep_wake <= 1'b0;
    // Settling codes 0 to 4 and 7; codes 4 and 7 must give the same count.
    for (int k = 0; k < 6; k++) begin
      code = codes[k];
      sh = (code > 3) ? 4 : code;
      wr(`PDM_OFF_CTRL_ONE, 32'h80 | (code << 4));
      slp();
      wait_mode(3'd2, 4);
      wr(`PDM_OFF_CTRL_ONE, code << 4);
      rchk(`PDM_OFF_CTRL_ONE, 32'h80 | (code << 4));
      wake_ext <= 1'b1;
      settle(sh, 1'b0);
      rchk(`PDM_OFF_CTRL_ONE, 32'h80 | (code << 4));
      sts();
    end
    tws <= 1'b1;
    wr(`PDM_OFF_CTRL_ONE, 32'h88);
    slp();
    wait_mode(3'd3, 4);
    chk(osc_run, 1'b0);
    to_sub();
    chk(cpu_sub, 1'b1);
    rchk(`PDM_OFF_MODE, 32'h4);
    wr(`PDM_OFF_CTRL_ONE, 32'h80);
    slp();
    wait_mode(3'd3, 4);
    to_sub();
    wr(`PDM_OFF_CTRL_TWO, 32'h08 | exp_c2);
    rchk(`PDM_OFF_CTRL_TWO, exp_c2);
    for (int j = 0; j < 2; j++) begin
      wr(`PDM_OFF_CTRL_ONE, 32'h80);
      gmask <= (j == 0);
      dt_en <= (j == 0);
      slp();
      wait_mode(3'd3, 4);
      gmask <= 1'b0;
      dt_en <= 1'b1;
      to_sub();
    end
    wr(`PDM_OFF_CTRL_ONE, 32'h80);
    slp();
    settle(0, 1'b1);
    chk(cpu_sub, 1'b0);
    sts();
    test_done();
  end
endmodule
`default_nettype wire
